// file: fpiu_pkg.sv
package fpiu_pkg;
  localparam logic [7:0]  IOPT_ADDR      = 8'hc8;
  localparam int          IOPT_EL1_BIT   = 6;
  localparam int          IOPT_ES2_BIT   = 5;
  localparam int          IOPT_GEN_BIT   = 4;
  localparam logic [2:0]  IOPT_RESET     = 3'h0;
  localparam logic [11:0] VEC_NMI        = 12'hffc;
  localparam logic [11:0] VEC_1          = 12'hff6;
  localparam logic [11:0] VEC_2          = 12'hff4;
  localparam logic [11:0] VEC_3          = 12'hff2;
  localparam logic [11:0] VEC_4          = 12'hff0;
  localparam logic [11:0] VEC_NONE       = 12'h000;
  localparam logic [1:0]  LVL_NORMAL     = 2'h0;
  localparam logic [1:0]  LVL_IRQ        = 2'h1;
  localparam logic [1:0]  LVL_NMI        = 2'h2;
  typedef enum logic [1:0] {
    FPIU_MODE_NORMAL = 2'b00,
    FPIU_MODE_IRQ    = 2'b01,
    FPIU_MODE_NMI    = 2'b11
  } fpiu_mode_t;
endpackage : fpiu_pkg

// file: fpiu_top.sv
`timescale 1ns/1ps
module fpiu_top
  import fpiu_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        reset_in,
  input  wire logic        data_wr_in,
  input  wire logic [7:0]  data_addr_in,
  input  wire logic [7:0]  data_wdata_in,
  input  wire logic        ir_input_pin_in,
  input  wire logic        ir_latch_enable_in,
  input  wire logic        ir_latch_clear_in,
  input  wire logic        power_key_pin_in,
  input  wire logic        power_key_enable_in,
  input  wire logic        power_key_clear_in,
  input  wire logic        vsync_pin_in,
  input  wire logic        vsync_enable_in,
  input  wire logic        timer1_zero_flag_in,
  input  wire logic        timer1_irq_mask_in,
  input  wire logic        timer2_zero_flag_in,
  input  wire logic        timer2_irq_mask_in,
  input  wire logic        last_cycle_in,
  input  wire logic        return_from_irq_in,
  output logic             accept_out,
  output logic [11:0]      vector_out,
  output logic [1:0]       flag_set_out,
  output logic             push_pc_out,
  output logic             pop_pc_out,
  output logic             ir_latch_out,
  output logic [4:0]       pending_out
);

  // option register fields
  logic       el1_q, el1_d;
  logic       es2_q, es2_d;
  logic       gen_q, gen_d;

  always_comb begin
    el1_d = el1_q;
    es2_d = es2_q;
    gen_d = gen_q;
    if (data_wr_in && (data_addr_in == IOPT_ADDR)) begin
      el1_d = data_wdata_in[IOPT_EL1_BIT];
      es2_d = data_wdata_in[IOPT_ES2_BIT];
      gen_d = data_wdata_in[IOPT_GEN_BIT];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      {el1_q, es2_q, gen_q} <= IOPT_RESET;
    end else begin
      el1_q <= el1_d;
      es2_q <= es2_d;
      gen_q <= gen_d;
    end
  end

  // pin synchronisers: three stages, change when stages two and three agree
  // filters track the pin during reset, so release shows no false edge
  logic [2:0] ir_s_q, pk_s_q, vs_s_q;
  logic       ir_f_q, pk_f_q, vs_f_q;
  logic       ir_f_d, pk_f_d, vs_f_d;

  always_comb begin
    ir_f_d = (reset_in || (ir_s_q[1] == ir_s_q[2])) ? ir_s_q[2] : ir_f_q;
    pk_f_d = (reset_in || (pk_s_q[1] == pk_s_q[2])) ? pk_s_q[2] : pk_f_q;
    vs_f_d = (reset_in || (vs_s_q[1] == vs_s_q[2])) ? vs_s_q[2] : vs_f_q;
  end

  always_ff @(posedge ref_clk_in) begin
    ir_s_q <= {ir_s_q[1:0], ir_input_pin_in};
    pk_s_q <= {pk_s_q[1:0], power_key_pin_in};
    vs_s_q <= {vs_s_q[1:0], vsync_pin_in};
    ir_f_q <= ir_f_d;
    pk_f_q <= pk_f_d;
    vs_f_q <= vs_f_d;
  end

  logic ir_edge, pk_edge, vs_rise, vs_fall;
  assign ir_edge = ir_f_d ^ ir_f_q;
  assign pk_edge = pk_f_d ^ pk_f_q;
  assign vs_rise = vs_f_d & ~vs_f_q;
  assign vs_fall = ~vs_f_d & vs_f_q;

  // source latches, the request lines they drive, and the timer request lines
  logic ir_lat_q, ir_lat_d;
  logic pk_lat_q, pk_lat_d;
  logic ir_request, power_key_request;
  logic t1_request, t2_request;

  always_comb begin
    ir_lat_d = ir_lat_q;
    pk_lat_d = pk_lat_q;
    if (ir_latch_clear_in) ir_lat_d = 1'b0;
    if (ir_latch_enable_in && ir_edge) ir_lat_d = 1'b1;
    if (power_key_clear_in) pk_lat_d = 1'b0;
    if (power_key_enable_in && pk_edge) pk_lat_d = 1'b1;
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      ir_lat_q <= 1'b0;
      pk_lat_q <= 1'b0;
    end else begin
      ir_lat_q <= ir_lat_d;
      pk_lat_q <= pk_lat_d;
    end
  end

  assign ir_request        = ~ir_lat_q;
  assign power_key_request = ~pk_lat_q;
  assign t2_request        = ~(timer2_zero_flag_in & timer2_irq_mask_in);
  assign t1_request        = ~(timer1_zero_flag_in & timer1_irq_mask_in);

  // edge flip-flops and level requests
  logic nmi_ff_q, nmi_ff_d, ir_req_prev_q;
  logic v1_ff_q, v1_ff_d, t2_prev_q;
  logic v2_ff_q, v2_ff_d;
  logic [4:0] pend;
  logic [4:0] grant;

  fpiu_mode_t mode_q, mode_d;
  fpiu_mode_t prev_q, prev_d;
  logic       sample;

  assign sample = last_cycle_in;

  always_comb begin
    nmi_ff_d = nmi_ff_q;
    v1_ff_d  = v1_ff_q;
    v2_ff_d  = v2_ff_q;
    if (grant[0]) nmi_ff_d = 1'b0;
    if (grant[1]) v1_ff_d = 1'b0;
    if (grant[2]) v2_ff_d = 1'b0;
    if (ir_req_prev_q && !ir_request) nmi_ff_d = 1'b1;
    if (!el1_q && t2_prev_q && !t2_request) v1_ff_d = 1'b1;
    if (vsync_enable_in && (es2_q ? vs_rise : vs_fall)) v2_ff_d = 1'b1;
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      nmi_ff_q      <= 1'b0;
      v1_ff_q       <= 1'b0;
      v2_ff_q       <= 1'b0;
      ir_req_prev_q <= 1'b1;
      t2_prev_q     <= 1'b1;
    end else begin
      nmi_ff_q      <= nmi_ff_d;
      v1_ff_q       <= v1_ff_d;
      v2_ff_q       <= v2_ff_d;
      ir_req_prev_q <= ir_request;
      t2_prev_q     <= t2_request;
    end
  end

  // stored flags survive global disable; gate only at selection
  always_comb begin
    pend[0] = nmi_ff_q;
    pend[1] = el1_q ? ~t2_request : v1_ff_q;
    pend[2] = v2_ff_q;
    pend[3] = ~t1_request;
    pend[4] = ~power_key_request;
  end

  // priority and mode sequencing
  logic       mask_ok;
  logic [11:0] vec_q, vec_d;
  logic       acc_q, acc_d, push_q, push_d, pop_q, pop_d;

  assign mask_ok = gen_q && (mode_q == FPIU_MODE_NORMAL);

  always_comb begin
    grant = 5'h0;
    if (sample && !return_from_irq_in) begin
      if (pend[0] && (mode_q != FPIU_MODE_NMI)) grant[0] = 1'b1;
      else if (mask_ok && pend[1]) grant[1] = 1'b1;
      else if (mask_ok && pend[2]) grant[2] = 1'b1;
      else if (mask_ok && pend[3]) grant[3] = 1'b1;
      else if (mask_ok && pend[4]) grant[4] = 1'b1;
    end
  end

  always_comb begin
    mode_d = mode_q;
    prev_d = prev_q;
    vec_d  = vec_q;
    acc_d  = 1'b0;
    push_d = 1'b0;
    pop_d  = 1'b0;
    if (sample && return_from_irq_in) begin
      mode_d = prev_q;
      prev_d = FPIU_MODE_NORMAL;
      pop_d  = 1'b1;
    end else if (grant != 5'h0) begin
      acc_d  = 1'b1;
      push_d = 1'b1;
      prev_d = mode_q;
      mode_d = grant[0] ? FPIU_MODE_NMI : FPIU_MODE_IRQ;
      case (1'b1)
        grant[0]: vec_d = VEC_NMI;
        grant[1]: vec_d = VEC_1;
        grant[2]: vec_d = VEC_2;
        grant[3]: vec_d = VEC_3;
        grant[4]: vec_d = VEC_4;
        default:  vec_d = VEC_NONE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      mode_q <= FPIU_MODE_NMI;
      prev_q <= FPIU_MODE_NORMAL;
      vec_q  <= VEC_NONE;
      acc_q  <= 1'b0;
      push_q <= 1'b0;
      pop_q  <= 1'b0;
    end else begin
      mode_q <= mode_d;
      prev_q <= prev_d;
      vec_q  <= vec_d;
      acc_q  <= acc_d;
      push_q <= push_d;
      pop_q  <= pop_d;
    end
  end

  always_comb begin
    case (mode_q)
      FPIU_MODE_NORMAL: flag_set_out = LVL_NORMAL;
      FPIU_MODE_IRQ:    flag_set_out = LVL_IRQ;
      FPIU_MODE_NMI:    flag_set_out = LVL_NMI;
      default:          flag_set_out = LVL_NMI;
    endcase
  end

  assign accept_out   = acc_q;
  assign vector_out   = vec_q;
  assign push_pc_out  = push_q;
  assign pop_pc_out   = pop_q;
  assign ir_latch_out = ir_lat_q;
  assign pending_out  = pend;

  // assertions
  property p_reset_nmi;
    @(posedge ref_clk_in) $fell(reset_in) |-> (mode_q == FPIU_MODE_NMI);
  endproperty
  a_reset_nmi: assert property (p_reset_nmi) else $error("not in nmi mode after reset");

  property p_nmi_vec;
    @(posedge ref_clk_in) disable iff (reset_in) grant[0] |=> (vector_out == VEC_NMI) && accept_out;
  endproperty
  a_nmi_vec: assert property (p_nmi_vec) else $error("nmi vector wrong");

  property p_no_nest;
    @(posedge ref_clk_in) disable iff (reset_in) (mode_q != FPIU_MODE_NORMAL) |-> (grant[4:1] == 4'h0);
  endproperty
  a_no_nest: assert property (p_no_nest) else $error("maskable nested");

  property p_prio;
    @(posedge ref_clk_in) disable iff (reset_in) (grant[2] || grant[3] || grant[4]) |-> !pend[1];
  endproperty
  a_prio: assert property (p_prio) else $error("priority order broken");

  property p_gen;
    @(posedge ref_clk_in) disable iff (reset_in) !gen_q |-> (grant[4:1] == 4'h0);
  endproperty
  a_gen: assert property (p_gen) else $error("maskable taken while disabled");

  property p_push;
    @(posedge ref_clk_in) disable iff (reset_in) accept_out |-> push_pc_out && (flag_set_out != LVL_NORMAL);
  endproperty
  a_push: assert property (p_push) else $error("accept without push or flag swap");

  property p_return_from_irq;
    @(posedge ref_clk_in) disable iff (reset_in)
      (sample && return_from_irq_in) |=> pop_pc_out && (mode_q == $past(prev_q));
  endproperty
  a_return_from_irq: assert property (p_return_from_irq) else $error("return did not restore mode");

  property p_hold;
    @(posedge ref_clk_in) disable iff (reset_in) (v2_ff_q && !grant[2]) |=> v2_ff_q;
  endproperty
  a_hold: assert property (p_hold) else $error("vsync flag lost before service");

  property p_only_last;
    @(posedge ref_clk_in) disable iff (reset_in) !sample |=> !accept_out;
  endproperty
  a_only_last: assert property (p_only_last) else $error("accept outside last cycle");

  sequence s_grant_any;
    (grant != 5'h0);
  endsequence

  sequence s_enter;
    accept_out && push_pc_out && (flag_set_out != LVL_NORMAL);
  endsequence

  property p_enter;
    @(posedge ref_clk_in) disable iff (reset_in) s_grant_any |=> s_enter;
  endproperty
  a_enter: assert property (p_enter) else $error("accept steps missing");

  property p_nmi_hold;
    @(posedge ref_clk_in) disable iff (reset_in) (nmi_ff_q && !grant[0]) |=> nmi_ff_q;
  endproperty
  a_nmi_hold: assert property (p_nmi_hold) else $error("nmi request lost before service");

  property p_ir_latch;
    @(posedge ref_clk_in) disable iff (reset_in) (ir_latch_enable_in && ir_edge) |=> ir_latch_out;
  endproperty
  a_ir_latch: assert property (p_ir_latch) else $error("ir pin edge not latched");

  property p_t1_mask;
    @(posedge ref_clk_in) disable iff (reset_in) !timer1_irq_mask_in |-> !pending_out[3];
  endproperty
  a_t1_mask: assert property (p_t1_mask) else $error("masked timer flag reached core");

  property p_vs_rise;
    @(posedge ref_clk_in) disable iff (reset_in) (vsync_enable_in && es2_q && vs_rise) |=> v2_ff_q;
  endproperty
  a_vs_rise: assert property (p_vs_rise) else $error("vsync rising edge not captured");

endmodule : fpiu_top

// file: fpiu_core_model.sv
`timescale 1ns/1ps
module fpiu_core_model (
  input  wire logic ref_clk_in,
  input  wire logic reset_in,
  input  wire logic ret_req_in,
  output logic      last_cycle_out,
  output logic      return_from_irq_out
);
  logic [1:0] cnt_q;
  logic       pend_q;
  // three-cycle instructions; a requested return rides the next last cycle
  always @(negedge ref_clk_in) begin
    if (reset_in) begin
      cnt_q <= 2'h0;
      pend_q <= 1'b0;
      last_cycle_out <= 1'b0;
      return_from_irq_out <= 1'b0;
    end else begin
      cnt_q <= (cnt_q == 2'h2) ? 2'h0 : cnt_q + 2'h1;
      last_cycle_out <= (cnt_q == 2'h2);
      return_from_irq_out <= (cnt_q == 2'h2) && (pend_q || ret_req_in);
      pend_q <= (pend_q || ret_req_in) && (cnt_q != 2'h2);
    end
  end
endmodule : fpiu_core_model

// file: fpiu_top_test.sv
`timescale 1ns/1ps
module fpiu_top_test;
  import fpiu_pkg::*;
  logic ref_clk_in, reset_in, data_wr_in, ir_input_pin_in, ir_latch_enable_in, ir_latch_clear_in;
  logic power_key_pin_in, power_key_enable_in, power_key_clear_in, vsync_pin_in, vsync_enable_in;
  logic timer1_zero_flag_in, timer1_irq_mask_in, timer2_zero_flag_in, timer2_irq_mask_in;
  logic last_cycle_in, return_from_irq_in, accept_out, push_pc_out, pop_pc_out, ir_latch_out, ret_req;
  logic [7:0]  data_addr_in, data_wdata_in;
  logic [11:0] vector_out;
  logic [1:0]  flag_set_out;
  logic [4:0]  pending_out;
  int          fail_count, comparisons;

  fpiu_top DUT (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .data_wr_in(data_wr_in),
    .data_addr_in(data_addr_in), .data_wdata_in(data_wdata_in), .ir_input_pin_in(ir_input_pin_in),
    .ir_latch_enable_in(ir_latch_enable_in), .ir_latch_clear_in(ir_latch_clear_in),
    .power_key_pin_in(power_key_pin_in), .power_key_enable_in(power_key_enable_in),
    .power_key_clear_in(power_key_clear_in), .vsync_pin_in(vsync_pin_in), .vsync_enable_in(vsync_enable_in),
    .timer1_zero_flag_in(timer1_zero_flag_in), .timer1_irq_mask_in(timer1_irq_mask_in),
    .timer2_zero_flag_in(timer2_zero_flag_in), .timer2_irq_mask_in(timer2_irq_mask_in),
    .last_cycle_in(last_cycle_in), .return_from_irq_in(return_from_irq_in), .accept_out(accept_out),
    .vector_out(vector_out), .flag_set_out(flag_set_out), .push_pc_out(push_pc_out), .pop_pc_out(pop_pc_out),
    .ir_latch_out(ir_latch_out), .pending_out(pending_out));
  fpiu_core_model core (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .ret_req_in(ret_req),
    .last_cycle_out(last_cycle_in), .return_from_irq_out(return_from_irq_in));

  initial begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  task automatic step(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask : step

  task automatic check(input logic [11:0] got, input logic [11:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : check

  // whole-byte write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    data_addr_in <= a;
    data_wdata_in <= d;
    data_wr_in <= 1'b1;
    step(1);
    data_wr_in <= 1'b0;
  endtask : wr

  task automatic got(input logic [11:0] vec, input logic [1:0] fs);
    int n = 0;
    while (accept_out !== 1'b1 && n < 40) begin
      step(1);
      n++;
    end
    check({11'h0, accept_out}, 12'h1, "accept");
    check(vector_out, vec, "vector");
    check({10'h0, flag_set_out}, {10'h0, fs}, "flag set");
    check({11'h0, push_pc_out}, 12'h1, "push");
    step(1);
  endtask : got

  task automatic none(input int n);
    repeat (n) begin
      step(1);
      check({11'h0, accept_out}, 12'h0, "unexpected accept");
    end
  endtask : none

  task automatic ret(input logic [1:0] fs);
    int n = 0;
    ret_req <= 1'b1;
    step(1);
    ret_req <= 1'b0;
    while (pop_pc_out !== 1'b1 && n < 20) begin
      step(1);
      n++;
    end
    check({11'h0, pop_pc_out}, 12'h1, "pop");
    check({10'h0, flag_set_out}, {10'h0, fs}, "restored flag set");
    step(1);
  endtask : ret

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask : done

  initial begin
    #150000;
    fail_count++;
    $display("BAD %0t watchdog expired", $time);
    end_of_test();
  end

  initial begin
    {reset_in, data_wr_in, ir_latch_clear_in, power_key_clear_in, ret_req} = 5'h10;
    {ir_input_pin_in, ir_latch_enable_in, power_key_pin_in, power_key_enable_in} = 4'hf;
    {vsync_pin_in, vsync_enable_in} = 2'h3;
    {timer1_zero_flag_in, timer1_irq_mask_in, timer2_zero_flag_in, timer2_irq_mask_in} = 4'h0;
    data_addr_in = 8'h00;
    data_wdata_in = 8'h00;
    fail_count = 0;
    comparisons = 0;
    repeat (4) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    reset_in <= 1'b0;
    step(1);
    check({10'h0, flag_set_out}, {10'h0, LVL_NMI}, "reset mode");
    check(vector_out, VEC_NONE, "reset vector");
    {timer1_zero_flag_in, timer1_irq_mask_in} <= 2'h3;
    ret(LVL_NORMAL);
    none(12);
    wr(IOPT_ADDR, 8'h10);
    got(VEC_3, LVL_IRQ);
    done("startup");
    {timer2_zero_flag_in, timer2_irq_mask_in} <= 2'h3;
    wr(IOPT_ADDR, 8'h50);
    none(12);
    ret(LVL_NORMAL);
    got(VEC_1, LVL_IRQ);
    timer2_zero_flag_in <= 1'b0;
    ret(LVL_NORMAL);
    got(VEC_3, LVL_IRQ);
    timer1_irq_mask_in <= 1'b0;
    ret(LVL_NORMAL);
    none(12);
    timer1_zero_flag_in <= 1'b0;
    done("priority");
    wr(IOPT_ADDR, 8'h40);
    vsync_pin_in <= 1'b0;
    step(6);
    vsync_pin_in <= 1'b1;
    step(6);
    vsync_pin_in <= 1'b0;
    none(12);
    check({7'h0, pending_out}, 12'h004, "pending vsync");
    wr(IOPT_ADDR, 8'h50);
    got(VEC_2, LVL_IRQ);
    ret(LVL_NORMAL);
    none(15);
    wr(IOPT_ADDR, 8'h70);
    vsync_pin_in <= 1'b1;
    got(VEC_2, LVL_IRQ);
    vsync_pin_in <= 1'b0;
    ret(LVL_NORMAL);
    none(15);
    done("vsync");
    wr(8'hc9, 8'h00);
    power_key_pin_in <= 1'b0;
    got(VEC_4, LVL_IRQ);
    power_key_clear_in <= 1'b1;
    step(1);
    power_key_clear_in <= 1'b0;
    ret(LVL_NORMAL);
    none(12);
    done("power key");
    {timer1_zero_flag_in, timer1_irq_mask_in} <= 2'h3;
    got(VEC_3, LVL_IRQ);
    ir_input_pin_in <= 1'b0;
    got(VEC_NMI, LVL_NMI);
    check({11'h0, ir_latch_out}, 12'h1, "ir latch");
    ir_latch_clear_in <= 1'b1;
    step(1);
    ir_latch_clear_in <= 1'b0;
    timer1_zero_flag_in <= 1'b0;
    step(1);
    check({11'h0, ir_latch_out}, 12'h0, "ir latch clear");
    ret(LVL_IRQ);
    ret(LVL_NORMAL);
    ir_latch_enable_in <= 1'b0;
    ir_input_pin_in <= 1'b1;
    none(12);
    done("nmi");
    wr(IOPT_ADDR, 8'h10);
    timer2_zero_flag_in <= 1'b1;
    got(VEC_1, LVL_IRQ);
    ret(LVL_NORMAL);
    none(12);
    timer2_zero_flag_in <= 1'b0;
    done("edge");
    end_of_test();
  end
endmodule : fpiu_top_test
